// ### core/sop_macrocell_array.v
// Programmable sum-of-products array, eight macrocells, Wishbone configured
//==========================================================================
`timescale 1ns/100ps
`include "sop_array_regs.vh"
`default_nettype none

module sop_macrocell_array #(
   parameter N_IN = 10,
   parameter N_MC = 8,
   parameter N_PT = 8
) (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [11:0] i_wb_adr,
   input wire [31:0] i_wb_dat,
   input wire [3:0] i_wb_sel,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   input wire [N_IN-1:0] i_in_pin,
   input wire [N_MC-1:0] i_io_pin,
   output reg [N_MC-1:0] o_io_pin,
   output reg [N_MC-1:0] o_io_oe
);

   localparam N_TERM = N_MC * (N_PT + 1);
   localparam N_LINE = 2 * (N_IN + N_MC);

   //=======================================================================
   // Reset release
   //=======================================================================
   reg rst_meta_n;
   reg rst_n;

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   //=======================================================================
   // Pin synchronisers
   //=======================================================================
   reg [N_IN-1:0] in_meta;
   reg [N_IN-1:0] in_sync;
   reg [N_MC-1:0] io_meta;
   reg [N_MC-1:0] io_sync;
   reg clk_pin_prev;
   wire clk_pin_rise;

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta <= {N_IN{1'b0}};
         in_sync <= {N_IN{1'b0}};
         io_meta <= {N_MC{1'b0}};
         io_sync <= {N_MC{1'b0}};
         clk_pin_prev <= 1'b0;
      end else begin
         in_meta <= i_in_pin;
         in_sync <= in_meta;
         io_meta <= i_io_pin;
         io_sync <= io_meta;
         clk_pin_prev <= in_sync[0];
      end
   end

   // Input 0 is the clock pin
   assign clk_pin_rise = in_sync[0] & ~clk_pin_prev;

   //=======================================================================
   // Configuration storage
   //=======================================================================
   reg [35:0] pt_mask [0:N_TERM-1];
   reg [15:0] mc_cfg [0:N_MC-1];
   reg [N_MC-1:0] mc_q;

   wire req;
   wire [2:0] adr_mc;
   wire [3:0] adr_pt;
   wire adr_hi;
   wire adr_pt_ok;
   wire [6:0] adr_idx;
   wire adr_cfg;
   wire adr_stat;

   assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign adr_mc = i_wb_adr[`PT_MC_LSB+2:`PT_MC_LSB];
   assign adr_pt = i_wb_adr[`PT_SEL_LSB+3:`PT_SEL_LSB];
   assign adr_hi = i_wb_adr[`PT_HALF_BIT];
   assign adr_pt_ok = (i_wb_adr[11:10] == `PT_REGION_TOP) &&
                      (adr_pt <= `PT_OE_INDEX) &&
                      (i_wb_adr[1:0] == 2'h0);
   assign adr_idx = {1'b0, adr_mc, 3'h0} + {4'h0, adr_mc} + {3'h0, adr_pt};
   assign adr_cfg = (i_wb_adr[11:5] == `CFG_WORD_TAG) &&
                    (i_wb_adr[1:0] == 2'h0);
   assign adr_stat = (i_wb_adr == `STAT_ADDR);

   integer k;
   integer b;

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < N_TERM; k = k + 1) begin
            if ((k % (N_PT + 1)) == N_PT) begin
               pt_mask[k] <= `PT_OE_RST;
            end else begin
               pt_mask[k] <= `PT_LOGIC_RST;
            end
         end
         for (k = 0; k < N_MC; k = k + 1) begin
            mc_cfg[k] <= `CFG_RST;
         end
      end else if (req && i_wb_we) begin
         if (adr_pt_ok) begin
            if (adr_hi) begin
               if (i_wb_sel[0]) begin
                  pt_mask[adr_idx][35:32] <= i_wb_dat[3:0];
               end
            end else begin
               for (b = 0; b < 4; b = b + 1) begin
                  if (i_wb_sel[b]) begin
                     pt_mask[adr_idx][8*b +: 8] <= i_wb_dat[8*b +: 8];
                  end
               end
            end
         end else if (adr_cfg) begin
            for (b = 0; b < 2; b = b + 1) begin
               if (i_wb_sel[b]) begin
                  mc_cfg[i_wb_adr[4:2]][8*b +: 8] <= i_wb_dat[8*b +: 8];
               end
            end
         end
      end
   end

   //=======================================================================
   // AND array and macrocells
   //=======================================================================
   wire [N_MC-1:0] fb;
   wire [N_LINE-1:0] lines;
   wire [N_TERM-1:0] pt_hit;
   wire [N_MC-1:0] sum;
   wire [N_MC-1:0] oe_term;
   wire [N_MC-1:0] out_val;

   // Clock pin stays an array input even when it clocks registers
   assign lines = {~fb, fb, ~in_sync, in_sync};

   genvar t;
   genvar m;
   generate
      for (t = 0; t < N_TERM; t = t + 1) begin : g_term
         sop_and_term #(
            .N_LINE(N_LINE)
         ) sop_and_term_i (
            .i_lines(lines),
            .i_mask(pt_mask[t]),
            .o_hit(pt_hit[t])
         );
      end
      for (m = 0; m < N_MC; m = m + 1) begin : g_mc
         sop_macrocell #(
            .N_PT(N_PT)
         ) sop_macrocell_i (
            .i_terms(pt_hit[m*(N_PT+1) +: N_PT]),
            .i_oe_term(pt_hit[m*(N_PT+1) + N_PT]),
            .i_cfg(mc_cfg[m]),
            .i_q(mc_q[m]),
            .i_pin_level(io_sync[m]),
            .o_sum(sum[m]),
            .o_out(out_val[m]),
            .o_oe(oe_term[m]),
            .o_fb(fb[m])
         );
      end
   endgenerate

   // Macrocell registers
   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mc_q <= {N_MC{1'b0}};
      end else if (clk_pin_rise) begin
         mc_q <= sum;
      end
   end

   // Pin drivers
   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_io_pin <= {N_MC{1'b0}};
         o_io_oe <= {N_MC{1'b0}};
      end else begin
         o_io_pin <= out_val;
         o_io_oe <= oe_term;
      end
   end

   //=======================================================================
   // Bus answer
   //=======================================================================
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h00000000;
      if (adr_pt_ok) begin
         if (adr_hi) begin
            next_rdata = {28'h0000000, pt_mask[adr_idx][35:32]};
         end else begin
            next_rdata = pt_mask[adr_idx][31:0];
         end
      end else if (adr_cfg) begin
         next_rdata = {16'h0000, mc_cfg[i_wb_adr[4:2]]};
      end else if (adr_stat) begin
         next_rdata[`STAT_IN_LSB +: N_IN] = in_sync;
         next_rdata[`STAT_IO_LSB +: N_MC] = io_sync;
         next_rdata[`STAT_Q_LSB +: N_MC] = mc_q;
      end
   end

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= req;
         if (req && !i_wb_we) begin
            o_wb_dat <= next_rdata;
         end else begin
            o_wb_dat <= 32'h00000000;
         end
      end
   end

endmodule // sop_macrocell_array

//==========================================================================
// One product term of the AND array
//==========================================================================
module sop_and_term #(
   parameter N_LINE = 36
) (
   input wire [N_LINE-1:0] i_lines,
   input wire [N_LINE-1:0] i_mask,
   output wire o_hit
);

   // Empty mask is always high; true and inverted of one line is low
   assign o_hit = &(~i_mask | i_lines);

endmodule // sop_and_term

//==========================================================================
// One macrocell: OR of logic terms, polarity, feedback and enable
//==========================================================================
module sop_macrocell #(
   parameter N_PT = 8
) (
   input wire [N_PT-1:0] i_terms,
   input wire i_oe_term,
   input wire [15:0] i_cfg,
   input wire i_q,
   input wire i_pin_level,
   output wire o_sum,
   output wire o_out,
   output wire o_oe,
   output wire o_fb
);

   wire [N_PT-1:0] pt_en;
   wire registered;
   wire fb_src;

   assign pt_en = i_cfg[`CFG_PTEN_LSB +: N_PT];
   assign registered = i_cfg[`CFG_REG_BIT];
   assign o_sum = |(i_terms & pt_en);
   assign o_oe = i_oe_term;
   assign o_out = (registered ? i_q : o_sum) ^ i_cfg[`CFG_OINV_BIT];
   // Combinatorial feedback is the pin level, own drive or external
   assign fb_src = registered ? i_q : i_pin_level;
   assign o_fb = i_cfg[`CFG_FBEN_BIT] &
                 (fb_src ^ i_cfg[`CFG_FBINV_BIT]);

endmodule // sop_macrocell

`default_nettype wire

// ### core/sop_array_regs.vh
// Register map, field positions and reset values of the macrocell array
`ifndef SOP_ARRAY_REGS_VH
`define SOP_ARRAY_REGS_VH

// Address regions (byte addresses, 12-bit bus address)
`define PT_REGION_TOP 2'b00
`define CFG_BASE 12'h400
`define STAT_ADDR 12'h420
`define CFG_WORD_TAG 7'h20

// Product term words: adr[9:7] macrocell, adr[6:3] term, adr[2] half
`define PT_HALF_BIT 2
`define PT_SEL_LSB 3
`define PT_MC_LSB 7
`define PT_OE_INDEX 4'h8
`define PT_PER_MC 9

// Array line layout inside one 36-bit product term mask
`define LINE_IN_T_LSB 0
`define LINE_IN_C_LSB 10
`define LINE_FB_T_LSB 20
`define LINE_FB_C_LSB 28

// Macrocell configuration fields
`define CFG_REG_BIT 0
`define CFG_OINV_BIT 1
`define CFG_FBEN_BIT 2
`define CFG_FBINV_BIT 3
`define CFG_PTEN_LSB 8

// Status fields
`define STAT_IN_LSB 0
`define STAT_IO_LSB 10
`define STAT_Q_LSB 18

// Reset values
`define CFG_RST 16'h0000
`define PT_LOGIC_RST 36'h000000000
`define PT_OE_RST 36'h000000401

`endif

// ### verification/sop_macrocell_array_assertions.sv
// Bus and pin timing checks for the macrocell array
`timescale 1ns/100ps
`default_nettype none
module sop_array_chk #(parameter N_IN = 10, parameter N_MC = 8) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [N_IN-1:0] i_in_pin,
   input wire logic [N_MC-1:0] i_io_pin,
   input wire logic [N_MC-1:0] o_io_pin,
   input wire logic [N_MC-1:0] o_io_oe
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic [2:0] calm;
   // Cycles with quiet pins and an idle bus
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         calm <= 3'h0;
      end else if ($stable(i_in_pin) && $stable(i_io_pin) && !i_wb_cyc) begin
         calm <= (calm == 3'h6) ? calm : calm + 3'h1;
      end else begin
         calm <= 3'h0;
      end
   end
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held");
   ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      |=> o_wb_ack) else $error("no ack");
   ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_stb))
      else $error("stray ack");
   rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data outside ack");
   rst_clear_a: assert property (disable iff (1'b0)
      !i_resetn |-> o_io_oe == '0 && o_io_pin == '0)
      else $error("pins live in reset");
   rst_hold_a: assert property ($rose(i_resetn) |->
      (o_io_oe == '0) [*3]) else $error("pin driven after reset");
   pin_settle_a: assert property (calm == 3'h6 |=> $stable(o_io_pin))
      else $error("pin moved with quiet inputs");
   oe_settle_a: assert property (calm == 3'h6 |=> $stable(o_io_oe))
      else $error("enable moved with quiet inputs");
endmodule // sop_array_chk
bind sop_macrocell_array sop_array_chk #(.N_IN(N_IN), .N_MC(N_MC))
   sop_array_chk_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .i_in_pin(i_in_pin), .i_io_pin(i_io_pin),
   .o_io_pin(o_io_pin), .o_io_oe(o_io_oe));
`default_nettype wire

// ### verification/board_model.sv
// Board model: drives and resolves the shared I/O lines
`timescale 1ns/100ps
`default_nettype none
module board_model #(parameter N_MC = 8) (
   input wire logic i_clk,
   input wire logic [N_MC-1:0] i_en,
   input wire logic [N_MC-1:0] i_val,
   input wire logic [N_MC-1:0] i_dev_pin,
   input wire logic [N_MC-1:0] i_dev_oe,
   output wire logic [N_MC-1:0] o_level
);
   logic [N_MC-1:0] held = '0;
   wire [N_MC-1:0] drv = i_dev_oe | i_en;
   // Undriven line settles at the inverse of its last driven level
   assign o_level = i_dev_oe & i_dev_pin | ~i_dev_oe & i_en & i_val
      | ~drv & ~held;
   always @(posedge i_clk) begin
      held <= drv & o_level | ~drv & held;
   end
endmodule // board_model
`default_nettype wire

// ### verification/sop_macrocell_array_tb.sv
// Self-checking bench for the macrocell array
`timescale 1ns/100ps
`include "sop_array_regs.vh"
`default_nettype none
module sop_macrocell_array_tb;
   logic clk = 0, rn = 1, cyc = 0, stb = 0, we = 0, look = 0, ack, qm;
   logic [11:0] adr = '0;
   logic [31:0] wd = '0, rd, seed = 32'h2CD9;
   logic [9:0] inp = '0;
   logic [7:0] en = 8'hFF, val = 8'hA5, lvl, dp, doe;
   logic [31:0] q[$];
   int n_compared = 0, miscompares = 0, cyc_n = 0;
   always #2.5 clk = ~clk;
   sop_macrocell_array sop_macrocell_array_i (.i_sys_clk(clk),
      .i_resetn(rn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hF), .o_wb_dat(rd),
      .o_wb_ack(ack), .i_in_pin(inp), .i_io_pin(lvl), .o_io_pin(dp),
      .o_io_oe(doe));
   board_model board_model_i (.i_clk(clk), .i_en(en), .i_val(val),
      .i_dev_pin(dp), .i_dev_oe(doe), .o_level(lvl));
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic [11:0] ta(input [2:0] m, input [3:0] t);
      ta = {2'b00, m, t, 3'b000};
   endfunction
   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      if (!w) q.push_back(d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk iff ack === 1'b1);
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
   endtask
   task pins(input logic [7:0] o, p);
      repeat (8) @(posedge clk);
      q.push_back({16'h0, o, p});
      look <= 1;
      @(posedge clk);
      look <= 0;
   endtask
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (ack === 1'b1 && !we) chk(rd, q.pop_front());
      if (look) chk({16'h0, doe, dp}, q.pop_front());
      if (cyc_n == 20000) begin
         miscompares++;
         stop_test;
      end
   end
   initial begin
      rn <= 0;
      repeat (12) @(posedge clk);
      rn <= 1;
      repeat (3) @(posedge clk);
      inp <= 10'h2A6;
      pins(8'h00, 8'h00);
      bus(0, `STAT_ADDR, {14'h0, 8'hA5, 10'h2A6});
      bus(0, 12'h7FC, 32'h0);
      bus(0, ta(0, 9), 32'h0);
      $display("reset and map test done");
      en <= 8'hEA;
      bus(1, ta(0, 0), 32'h2);
      bus(1, ta(0, 8), 32'h1000);
      bus(1, ta(2, 0), 32'h200000);
      bus(1, ta(2, 8), 32'h0);
      bus(1, ta(4, 0), 32'h2);
      bus(1, ta(4, 8), 32'h0);
      bus(1, `CFG_BASE, 32'h100);
      bus(1, `CFG_BASE + 12'h4, 32'h104);
      bus(1, `CFG_BASE + 12'h8, 32'h102);
      bus(1, `CFG_BASE + 12'h10, 32'h101);
      bus(0, ta(0, 8), 32'h1000);
      qm = 0;
      repeat (6) begin
         seed = lfsr(seed);
         inp <= {7'h0, seed[1:0], 1'b0};
         val <= {6'h29, seed[2], 1'b1};
         pins({5'h2, 2'b10, ~seed[1]},
            {3'h0, qm, 1'b0, ~seed[2], 1'b1, seed[0]});
         inp[0] <= 1;
         repeat (4) @(posedge clk);
         inp[0] <= 0;
         qm = seed[0];
      end
      $display("logic test done");
      stop_test;
   end
endmodule // sop_macrocell_array_tb
`default_nettype wire
